// ===== verilog/backlight_pkg.sv
// shared constants, register map and state codes for the backlight sequencer
package backlight_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int CNT_W         = 24;
  localparam int CH_N          = 6;
  localparam int EN_TO_MS      = 28;
  localparam int EN_TO_CYC     = EN_TO_MS * 1000 * CLK_MHZ;
  localparam int SS_MIN_MS     = 8;
  localparam int OPEN_TO_PWM   = 6;
  localparam int SHORT_TO_PWM  = 6;
  localparam int OPEN_HOT_US   = 800;
  localparam int OPEN_HOT_CYC  = OPEN_HOT_US * CLK_MHZ;
  localparam int SW_PERIOD_DEF = 25;
  localparam int SW_MAX_ON_DEF = 20;

  // ----------------------------------------------------------------
  // soft-start current limit ladder
  // ----------------------------------------------------------------
  localparam int ILIM_STEP_MA  = 275;
  localparam int ILIM_FINAL_MA = 2200;
  localparam int ILIM_STEPS    = ILIM_FINAL_MA / ILIM_STEP_MA;
  localparam int ILIM_W        = 3;
  localparam logic [ILIM_W-1:0] ILIM_LAST = ILIM_W'(ILIM_STEPS - 1);
  localparam int SS_TOTAL_CYC  = SS_MIN_MS * 1000 * CLK_MHZ;
  localparam int SS_STEP_CYC   = (SS_TOTAL_CYC + ILIM_STEPS - 1) / ILIM_STEPS;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int IX_PWM   = 0;
  localparam int IX_EN    = 1;
  localparam int IX_OVPL  = 2;
  localparam int IX_OVP20 = 3;
  localparam int IX_HOT   = 4;
  localparam int IX_GATE  = 5;
  localparam int IX_NODE  = 6;
  localparam int IX_LOCK  = 7;
  localparam int IX_IOC   = 8;
  localparam int IX_STBL  = 9;
  localparam int IX_ILIM  = 10;
  localparam int IX_CUR   = 11;
  localparam int IX_SHORT = IX_CUR + CH_N;
  localparam int SYNC_W   = IX_SHORT + CH_N;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STAT = 4'h4;
  localparam logic [AXI_AW-1:0] REG_CHAN = 4'h8;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam int STAT_ST_LSB    = 0;
  localparam int STAT_ILIM_LSB  = 4;
  localparam int STAT_PROT_BIT  = 8;
  localparam int STAT_IOC_BIT   = 9;
  localparam int STAT_ENOFF_BIT = 10;
  localparam int STAT_ARM_BIT   = 11;
  localparam int CHAN_GOOD_LSB  = 0;
  localparam int CHAN_OPEN_LSB  = 8;
  localparam int CHAN_DIS_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF       = 3'b000,
    ST_NODE_TEST = 3'b001,
    ST_INRUSH    = 3'b010,
    ST_SOFT      = 3'b011,
    ST_RUN       = 3'b100,
    ST_FAULT     = 3'b101
  } seq_state_t;

endpackage : backlight_pkg

// ===== verilog/channel_guard.sv
// per-channel good / open / short classification and disable timing
`timescale 1ns/100ps
module channel_guard
  import backlight_pkg::*;
#(
  parameter logic [CNT_W-1:0] OPEN_PWM = CNT_W'(OPEN_TO_PWM),
  parameter logic [CNT_W-1:0] SHORT_PWM = CNT_W'(SHORT_TO_PWM),
  parameter logic [CNT_W-1:0] OPEN_HOT = CNT_W'(OPEN_HOT_CYC)
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clr,
  input  wire logic eval,
  input  wire logic pwm_rise,
  input  wire logic current_ok,
  input  wire logic short_hi,
  input  wire logic force_open,
  input  wire logic hot,
  input  wire logic stable,
  output wire logic good,
  output wire logic open,
  output wire logic dis
);

  typedef struct packed {
    logic             good;
    logic             open;
    logic             dis;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] scnt;
  } guard_t;

  guard_t q;
  guard_t n;
  logic   expired;

  always_comb begin
    n = q;
    expired = 1'b0;
    if (clr) begin
      n = '0;
    end else if (!q.dis) begin
      if (eval && current_ok) begin
        n.good = 1'b1;
        n.open = 1'b0;
      end
      if (eval && !current_ok && q.good && !q.open) begin
        n.good = 1'b0;
        n.open = 1'b1;
        n.cnt  = '0;
      end
      if (force_open && !q.good && !q.open) begin
        n.open = 1'b1;
        n.cnt  = '0;
      end
      if (q.open) begin
        if (hot || pwm_rise) begin
          n.cnt = q.cnt + 1'b1;
        end
        expired = hot ? (q.cnt >= OPEN_HOT - 1'b1) : (q.cnt >= OPEN_PWM);
      end
      if (eval && short_hi) begin
        if (pwm_rise) begin
          n.scnt = q.scnt + 1'b1;
        end
      end else if (eval) begin
        n.scnt = '0;
      end
      if (stable && (expired || q.scnt >= SHORT_PWM)) begin
        n.dis = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign good = q.good;
  assign open = q.open;
  assign dis  = q.dis;

endmodule : channel_guard

// ===== verilog/backlight_sequencer.sv
// backlight start-up, protection and channel control with an axi4-lite slave
`timescale 1ns/100ps
// Operation
// - channels follow incoming dimming pwm unchanged
// - sink gate pull-down current at start-up
// - boost switching only after switch fully on
// - end on-time when current limit exceeded
// - limit starts lowest, seven equal steps up
// - stepping at least minimum time, stretched
// - no channel disable while operation unstable
// - input overcurrent shuts all channels down
// - disable channel held above short threshold
// - channel good once current reaches target
// - good channel losing current becomes open
// - overvoltage or hot marks non-good open
// - open starts timeout, shorter when hot
// - zener-bypassed string stays unless overvoltage or hot
// - low input stops switching, resets state
// - test current, need switch node threshold
// - overvoltage sense rise then fall trips switch
// - enable inactive past timeout enters shutdown
// - normal open timeout is six pwm cycles
// - hot open timeout has fixed duration
module backlight_sequencer
  import backlight_pkg::*;
#(
  parameter logic [CNT_W-1:0] EN_TO     = CNT_W'(EN_TO_CYC),
  parameter logic [CNT_W-1:0] SS_STEP   = CNT_W'(SS_STEP_CYC),
  parameter logic [CNT_W-1:0] OPEN_HOT  = CNT_W'(OPEN_HOT_CYC),
  parameter logic [7:0]       SW_PERIOD = 8'(SW_PERIOD_DEF),
  parameter logic [7:0]       SW_MAX_ON = 8'(SW_MAX_ON_DEF)
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              pwm_in,
  input  wire logic              en_in,
  input  wire logic              ovp_limit,
  input  wire logic              ovp_above_frac,
  input  wire logic              temp_low_hot,
  input  wire logic              gate_full_on,
  input  wire logic              switch_node_ok,
  input  wire logic              low_input_lockout,
  input  wire logic              input_overcurrent,
  input  wire logic              leds_stable,
  input  wire logic              sw_over_limit,
  input  wire logic [CH_N-1:0]   ch_current_ok,
  input  wire logic [CH_N-1:0]   ch_short_hi,
  output wire logic [CH_N-1:0]   led_channel_sinks,
  output wire logic              gate_sink_en,
  output wire logic              node_test_en,
  output wire logic              boost_gate,
  output wire logic [ILIM_W-1:0] ilim_code,
  output wire logic              protect_switch_off,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic              pwm_d;
    seq_state_t        st;
    logic [CNT_W-1:0]  tmr;
    logic [ILIM_W-1:0] ilim;
    logic              pwm_seen;
    logic [CNT_W-1:0]  en_cnt;
    logic              en_off;
    logic [7:0]        sw_cnt;
    logic              gate;
    logic              ovp_arm;
    logic              prot_off;
    logic              ioc_fault;
    logic              sw_off;
    logic [CH_N-1:0]   ch_en;
    logic              sink;
    logic              node_test;
    logic              run_allow;
    logic              clr_req;
    logic              aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_full;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } seq_t;

  seq_t            q;
  seq_t            n;
  logic [CH_N-1:0] good;
  logic [CH_N-1:0] open;
  logic [CH_N-1:0] dis;
  logic            go;
  logic            switching;
  logic            wrap;
  logic            eval;
  logic            pwm_rise;
  logic            stable;
  logic            ch_clr;

  // ----------------------------------------------------------------
  // per-channel guards
  // ----------------------------------------------------------------
  assign pwm_rise = q.s2[IX_PWM] & ~q.pwm_d;
  assign eval     = q.s2[IX_PWM] & (q.st == ST_SOFT || q.st == ST_RUN);
  assign stable   = q.s2[IX_STBL] & (q.st == ST_RUN);
  assign ch_clr   = q.s2[IX_LOCK] | q.clr_req;

  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    channel_guard #(
      .OPEN_PWM  (CNT_W'(OPEN_TO_PWM)),
      .SHORT_PWM (CNT_W'(SHORT_TO_PWM)),
      .OPEN_HOT  (OPEN_HOT)
    ) u_guard (
      .clk        (clk),
      .srst       (srst),
      .clr        (ch_clr),
      .eval       (eval),
      .pwm_rise   (pwm_rise),
      .current_ok (q.s2[IX_CUR + i]),
      .short_hi   (q.s2[IX_SHORT + i]),
      .force_open (q.s2[IX_OVPL] | q.s2[IX_HOT]),
      .hot        (q.s2[IX_HOT]),
      .stable     (stable),
      .good       (good[i]),
      .open       (open[i]),
      .dis        (dis[i])
    );
  end

  // ----------------------------------------------------------------
  // sequencer, protection and bus slave
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    n.s1 = {ch_short_hi, ch_current_ok, sw_over_limit, leds_stable,
            input_overcurrent, low_input_lockout, switch_node_ok,
            gate_full_on, temp_low_hot, ovp_above_frac, ovp_limit,
            en_in, pwm_in};
    n.s2 = q.s1;
    n.pwm_d = q.s2[IX_PWM];
    n.clr_req = 1'b0;

    if (q.s2[IX_EN]) begin
      n.en_cnt = '0;
      n.en_off = 1'b0;
    end else if (q.en_cnt >= EN_TO - 1'b1) begin
      n.en_off = 1'b1;
    end else begin
      n.en_cnt = q.en_cnt + 1'b1;
    end

    go = q.run_allow & ~q.en_off & ~q.s2[IX_LOCK];
    switching = (q.st == ST_SOFT) || (q.st == ST_RUN);

    case (q.st)
      ST_OFF: begin
        if (go) begin
          n.st = ST_NODE_TEST;
        end
      end
      ST_NODE_TEST: begin
        if (q.s2[IX_NODE]) begin
          n.st = ST_INRUSH;
        end
      end
      ST_INRUSH: begin
        if (q.s2[IX_GATE]) begin
          n.st       = ST_SOFT;
          n.ilim     = '0;
          n.tmr      = '0;
          n.pwm_seen = 1'b0;
        end
      end
      ST_SOFT: begin
        n.tmr      = q.tmr + 1'b1;
        n.pwm_seen = q.pwm_seen | pwm_rise;
        if (q.tmr >= SS_STEP - 1'b1 && q.pwm_seen) begin
          n.tmr      = '0;
          n.pwm_seen = 1'b0;
          if (q.ilim == ILIM_LAST) begin
            n.st = ST_RUN;
          end else begin
            n.ilim = q.ilim + 1'b1;
          end
        end
      end
      ST_RUN: begin
        n.ilim = ILIM_LAST;
      end
      ST_FAULT: begin
        n.st = ST_FAULT;
      end
      default: begin
        n.st = ST_OFF;
      end
    endcase

    if (switching) begin
      if (q.s2[IX_OVP20]) begin
        n.ovp_arm = 1'b1;
      end else if (q.ovp_arm) begin
        n.prot_off = 1'b1;
      end
    end
    if (q.st != ST_OFF && q.s2[IX_IOC]) begin
      n.ioc_fault = 1'b1;
    end
    if (n.prot_off || n.ioc_fault) begin
      n.st = ST_FAULT;
    end
    if (!go) begin
      n.st        = ST_OFF;
      n.ilim      = '0;
      n.tmr       = '0;
      n.ovp_arm   = 1'b0;
      n.prot_off  = 1'b0;
      n.ioc_fault = 1'b0;
    end
    n.sw_off = n.prot_off | n.ioc_fault;

    wrap = (q.sw_cnt >= SW_PERIOD - 1'b1);
    n.sw_cnt = wrap ? '0 : q.sw_cnt + 1'b1;
    n.gate = (n.st == ST_SOFT || n.st == ST_RUN) && !q.s2[IX_ILIM] &&
             (wrap || (q.gate && q.sw_cnt < SW_MAX_ON));

    n.sink = (n.st == ST_INRUSH) || (n.st == ST_SOFT) || (n.st == ST_RUN);
    n.node_test = (n.st == ST_NODE_TEST);
    n.ch_en = ((n.st == ST_SOFT || n.st == ST_RUN) && q.s2[IX_PWM] &&
               !q.s2[IX_IOC]) ? ~dis : '0;

    // write channel: address and data in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_full = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_full = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      case (q.aw_addr[AXI_AW-1:2])
        REG_CTRL[AXI_AW-1:2]: begin
          if (q.wstrb[0]) begin
            n.run_allow = q.wdata[CTRL_RUN_BIT];
            n.clr_req   = q.wdata[CTRL_CLR_BIT];
          end
        end
        REG_STAT[AXI_AW-1:2], REG_CHAN[AXI_AW-1:2]: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end
    n.awready = ~n.aw_full & ~n.bvalid;
    n.wready  = ~n.w_full & ~n.bvalid;

    // read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata  = 32'h0000_0000;
      n.rresp  = RESP_OKAY;
      case (s_axi_araddr[AXI_AW-1:2])
        REG_CTRL[AXI_AW-1:2]: begin
          n.rdata[CTRL_RUN_BIT] = q.run_allow;
        end
        REG_STAT[AXI_AW-1:2]: begin
          n.rdata[STAT_ST_LSB +: 3]       = q.st;
          n.rdata[STAT_ILIM_LSB +: ILIM_W] = q.ilim;
          n.rdata[STAT_PROT_BIT]          = q.prot_off;
          n.rdata[STAT_IOC_BIT]           = q.ioc_fault;
          n.rdata[STAT_ENOFF_BIT]         = q.en_off;
          n.rdata[STAT_ARM_BIT]           = q.ovp_arm;
        end
        REG_CHAN[AXI_AW-1:2]: begin
          n.rdata[CHAN_GOOD_LSB +: CH_N] = good;
          n.rdata[CHAN_OPEN_LSB +: CH_N] = open;
          n.rdata[CHAN_DIS_LSB +: CH_N]  = dis;
        end
        default: begin
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.arready = ~n.rvalid;
  end

  // en_off starts set so the device stays off until enable is seen high
  always_ff @(posedge clk) begin
    if (srst) begin
      q           <= '0;
      q.run_allow <= CTRL_RUN_RST;
      q.en_off    <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign led_channel_sinks  = q.ch_en;
  assign gate_sink_en       = q.sink;
  assign node_test_en       = q.node_test;
  assign boost_gate         = q.gate;
  assign ilim_code          = q.ilim;
  assign protect_switch_off = q.sw_off;
  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_arready      = q.arready;
  assign s_axi_rdata        = q.rdata;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rvalid       = q.rvalid;

endmodule : backlight_sequencer

// ===== test/seq_properties.sv
// assertions on the backlight sequencer ports
`timescale 1ns/100ps
module seq_properties
  import backlight_pkg::*;
#(
  parameter logic [CNT_W-1:0] EN_TO   = CNT_W'(EN_TO_CYC),
  parameter logic [CNT_W-1:0] SS_STEP = CNT_W'(SS_STEP_CYC)
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              pwm_in,
  input wire logic              en_in,
  input wire logic              low_input_lockout,
  input wire logic              sw_over_limit,
  input wire logic              gate_full_on,
  input wire logic [CH_N-1:0]   led_channel_sinks,
  input wire logic              node_test_en,
  input wire logic              boost_gate,
  input wire logic [ILIM_W-1:0] ilim_code,
  input wire logic              protect_switch_off
);
  logic [CNT_W-1:0]  gap_q;
  logic [CNT_W-1:0]  enlo_q;
  logic [ILIM_W-1:0] ilim_q;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // dwell since the last limit change; enable-low time saturates so it never wraps
  always_ff @(posedge clk) begin
    ilim_q <= ilim_code;
    gap_q  <= (srst || ilim_code != ilim_q) ? '0 : gap_q + 1'b1;
    if (srst || en_in) begin
      enlo_q <= '0;
    end else if (enlo_q < EN_TO + 24'h00_0008) begin
      enlo_q <= enlo_q + 1'b1;
    end
  end

  sink_follow_a:
    assert property (|led_channel_sinks |-> $past(pwm_in, 2) || $past(pwm_in, 3))
      else $error("sink on while dimming input low");
  boost_gated_a:
    assert property (boost_gate |-> !node_test_en && $past(gate_full_on, 3))
      else $error("boost switching before switch fully on");
  limit_cut_a:
    assert property (sw_over_limit [*5] |-> !(boost_gate && $past(boost_gate)))
      else $error("on-time not ended at current limit");
  ilim_ladder_a:
    assert property (ilim_code != $past(ilim_code)
      |-> ilim_code == $past(ilim_code) + 3'h1 || ilim_code == 3'h0)
      else $error("limit step not by one");
  ilim_dwell_a:
    assert property (ilim_code != 3'h0 && ilim_code != $past(ilim_code)
      |-> gap_q >= SS_STEP - 24'h00_0001)
      else $error("limit step too early");
  trip_quiet_a:
    assert property (protect_switch_off |=> led_channel_sinks == '0 && !boost_gate)
      else $error("outputs active after trip");
  lockout_off_a:
    assert property (low_input_lockout [*5] |-> !boost_gate && led_channel_sinks == '0)
      else $error("active during lockout");
  en_timeout_a:
    assert property (enlo_q > EN_TO + 24'h00_0006 |-> !boost_gate && led_channel_sinks == '0)
      else $error("active after enable timeout");

  cover property (ilim_code == 3'h7);
  cover property ($rose(protect_switch_off));
  cover property (sw_over_limit && boost_gate);
endmodule : seq_properties

// ===== test/led_partner.sv
// stand-in for comparators, protection switch and dimming source
`timescale 1ns/100ps
module led_partner
  import backlight_pkg::*;
#(
  parameter int PWM_PER = 40
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            node_test_en,
  input  wire logic            gate_sink_en,
  input  wire logic            boost_gate,
  input  wire logic            protect_switch_off,
  input  wire logic [CH_N-1:0] broken,
  output wire logic            pwm_in,
  output wire logic            switch_node_ok,
  output wire logic            gate_full_on,
  output wire logic            sw_over_limit,
  output wire logic [CH_N-1:0] ch_current_ok
);
  logic [7:0] pcnt_q;
  logic [4:0] node_q;
  logic [4:0] gate_q;
  logic [3:0] on_q;
  logic [3:0] oc_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      pcnt_q <= 8'h00;
      node_q <= 5'h00;
      gate_q <= 5'h00;
      on_q   <= 4'h0;
      oc_q   <= 4'h0;
    end else begin
      pcnt_q <= (pcnt_q == 8'(PWM_PER - 1)) ? 8'h00 : pcnt_q + 8'h01;
      // node charges only while test current flows, then holds
      if (node_test_en && node_q < 5'h10) node_q <= node_q + 5'h01;
      // a trip opens the switch; it re-enhances slowly under the gate sink
      if (protect_switch_off) gate_q <= 5'h00;
      else if (gate_sink_en && gate_q < 5'h10) gate_q <= gate_q + 5'h01;
      on_q <= !boost_gate ? 4'h0 : (on_q == 4'hF ? on_q : on_q + 4'h1);
      // inductor passes the limit six cycles into each on-time
      oc_q <= (boost_gate && on_q == 4'h6) ? 4'h6 : (oc_q == 4'h0 ? 4'h0 : oc_q - 4'h1);
    end
  end

  assign pwm_in         = pcnt_q < 8'(PWM_PER / 2);
  assign switch_node_ok = node_q == 5'h10;
  assign gate_full_on   = gate_q == 5'h10;
  assign sw_over_limit  = oc_q != 4'h0;
  assign ch_current_ok  = ~broken;
endmodule : led_partner

// ===== test/tb_backlight_sequencer.sv
// self-checking bench for the backlight sequencer
`timescale 1ns/100ps
module tb_backlight_sequencer
  import backlight_pkg::*;
;
  logic clk, srst = 1'b1, pwm_in, en_in = 1'b0, ovp_limit = 1'b0, ovp_above_frac = 1'b0;
  logic temp_low_hot = 1'b0, low_input_lockout = 1'b0, input_overcurrent = 1'b0;
  logic leds_stable = 1'b1, gate_full_on, switch_node_ok, sw_over_limit;
  logic gate_sink_en, node_test_en, boost_gate, protect_switch_off;
  logic [CH_N-1:0] ch_current_ok, led_channel_sinks, broken = '0, ch_short_hi = '0;
  logic [ILIM_W-1:0] ilim_code;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int   n_errors = 0, cmp_count = 0;
  time  t0;

  backlight_sequencer #(.EN_TO(24'h00_0032), .SS_STEP(24'h00_0014), .OPEN_HOT(24'h00_001E))
  DUT (.clk, .srst, .pwm_in, .en_in, .ovp_limit, .ovp_above_frac, .temp_low_hot,
    .gate_full_on, .switch_node_ok, .low_input_lockout, .input_overcurrent, .leds_stable,
    .sw_over_limit, .ch_current_ok, .ch_short_hi, .led_channel_sinks, .gate_sink_en,
    .node_test_en, .boost_gate, .ilim_code, .protect_switch_off, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  led_partner #(.PWM_PER(40)) u_far (.clk, .srst, .node_test_en, .gate_sink_en,
    .boost_gate, .protect_switch_off, .broken, .pwm_in, .switch_node_ok, .gate_full_on,
    .sw_over_limit, .ch_current_ok);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    @(posedge clk);
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AXI_AW-1:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic wait_st(input logic [2:0] s);
    do rd(REG_STAT); while (rdat[2:0] !== s);
  endtask : wait_st

  // land a few cycles into a dimming high phase, past the sync delay
  task automatic at_hi;
    do @(posedge clk); while (pwm_in);
    do @(posedge clk); while (!pwm_in);
    cyc(5);
  endtask : at_hi

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    cyc(20000);
    n_errors++;
    conclude();
  end

  initial begin
    cyc(20);
    srst <= 1'b0;
    rd(REG_CTRL);
    chk("ctrl_rst", rdat, 32'h0000_0001);
    rd(4'hC);
    chk("unm_resp", {30'h0, rrsp}, 32'h0000_0002);
    chk("unm_data", rdat, 32'h0000_0000);
    $display("end registers");
    en_in <= 1'b1;
    wait_st(3'h1);
    chk("node_test", 32'(node_test_en), 32'h1);
    chk("boost_early", 32'(boost_gate), 32'h0);
    wait_st(3'h2);
    chk("gate_sink", 32'(gate_sink_en), 32'h1);
    wait_st(3'h3);
    t0 = $time;
    wait_st(3'h4);
    chk("ilim_final", 32'(ilim_code), 32'h7);
    chk("ss_long", 32'($time - t0 >= 7 * 20 * 40), 32'h1);
    $display("end start-up");
    cyc(100);
    rd(REG_CHAN);
    chk("all_good", rdat, 32'h0000_003F);
    at_hi();
    chk("sinks_hi", 32'(led_channel_sinks), 32'h3F);
    leds_stable <= 1'b0;
    broken <= 6'h04;
    cyc(400);
    rd(REG_CHAN);
    chk("open_unstable", rdat, 32'h0000_043B);
    leds_stable <= 1'b1;
    cyc(320);
    rd(REG_CHAN);
    chk("open_dis", 32'(rdat[21:16]), 32'h04);
    at_hi();
    chk("sinks_dis", 32'(led_channel_sinks), 32'h3B);
    ch_short_hi <= 6'h10;
    cyc(400);
    rd(REG_CHAN);
    chk("short_dis", 32'(rdat[21:16]), 32'h14);
    $display("end channels");
    broken <= 6'h01;
    ch_short_hi <= 6'h00;
    temp_low_hot <= 1'b1;
    wr(REG_CTRL, 32'h0000_0003);
    chk("wr_resp", 32'(brsp), 32'h0);
    cyc(100);
    rd(REG_CHAN);
    chk("hot_open", 32'({rdat[21:16], rdat[5:0]}), 32'h7E);
    temp_low_hot <= 1'b0;
    broken <= 6'h00;
    $display("end hot");
    input_overcurrent <= 1'b1;
    cyc(8);
    chk("trip_ioc", 32'(protect_switch_off), 32'h1);
    rd(REG_STAT);
    chk("stat_ioc", 32'({rdat[9], rdat[2:0]}), 32'hD);
    input_overcurrent <= 1'b0;
    at_hi();
    chk("sinks_trip", 32'(led_channel_sinks), 32'h0);
    low_input_lockout <= 1'b1;
    cyc(8);
    rd(REG_STAT);
    chk("lock_state", 32'(rdat[2:0]), 32'h0);
    chk("lock_prot", 32'(protect_switch_off), 32'h0);
    rd(REG_CHAN);
    chk("lock_chan", rdat, 32'h0000_0000);
    low_input_lockout <= 1'b0;
    broken <= 6'h20;
    wait_st(3'h4);
    cyc(100);
    rd(REG_CHAN);
    chk("zener_on", 32'(rdat[21:16]), 32'h00);
    ovp_limit <= 1'b1;
    cyc(8);
    ovp_limit <= 1'b0;
    cyc(300);
    rd(REG_CHAN);
    chk("ovp_open", 32'(rdat[21:16]), 32'h20);
    $display("end lockout");
    ovp_above_frac <= 1'b1;
    cyc(8);
    chk("frac_hi", 32'(protect_switch_off), 32'h0);
    ovp_above_frac <= 1'b0;
    cyc(8);
    chk("frac_fall", 32'(protect_switch_off), 32'h1);
    en_in <= 1'b0;
    cyc(40);
    rd(REG_STAT);
    chk("en_hold", 32'(rdat[10]), 32'h0);
    cyc(40);
    rd(REG_STAT);
    chk("en_off", 32'({rdat[10], rdat[2:0]}), 32'h8);
    $display("end protections");
    conclude();
  end
endmodule : tb_backlight_sequencer

bind backlight_sequencer seq_properties #(.EN_TO(EN_TO), .SS_STEP(SS_STEP)) u_props (
  .clk, .srst, .pwm_in, .en_in, .low_input_lockout, .sw_over_limit, .gate_full_on,
  .led_channel_sinks, .node_test_en, .boost_gate, .ilim_code, .protect_switch_off);
